// >>> common/art_pkg.sv
// Purpose: constants and carriers of the auto-reload pwm / capture timer
// Assumes: register index = printed offset, byte address = index * 4
// Notes:   all fields 8 bits wide, low byte lane of a 32-bit bus
package art_pkg;
	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_DUTY3    = 8'h31;
	localparam logic [7:0] IDX_DUTY2    = 8'h32;
	localparam logic [7:0] IDX_DUTY1    = 8'h33;
	localparam logic [7:0] IDX_DUTY0    = 8'h34;
	localparam logic [7:0] IDX_PWM_CTRL = 8'h35;
	localparam logic [7:0] IDX_TMR_CTRL = 8'h36;
	localparam logic [7:0] IDX_COUNT    = 8'h37;
	localparam logic [7:0] IDX_RELOAD   = 8'h38;
	localparam logic [7:0] IDX_CAP_CSR  = 8'h39;
	localparam logic [7:0] IDX_CAP1     = 8'h3A;
	localparam logic [7:0] IDX_CAP2     = 8'h3B;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h3C;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h3D;
	// ----------------------------------------------------------------
	// widths, resets, answers
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 10;
	localparam int         NUM_PWM     = 4;
	localparam int         NUM_CAP     = 2;
	localparam int         NUM_EVT     = 3;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [7:0] CNT_MAX     = 8'hFF;
	localparam logic [6:0] PRESC_ONES  = 7'h7F;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         EVT_OVF     = 0;
	localparam int         EVT_CAP1    = 1;
	localparam int         EVT_CAP2    = 2;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] pwm_output_enable;
		logic [3:0] pwm_output_polarity;
	} pwm_ctrl_t;
	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] edge_rising;
		logic [1:0] capture_irq_enable;
		logic [1:0] capture_flag;
	} cap_csr_t;
	typedef struct packed {
		logic [3:0] reserved;
		logic [2:0] presc_sel;
		logic       count_enable;
	} tmr_ctrl_t;
endpackage

// >>> hdl/art_pwm_timer.sv
// Purpose: 8-bit auto-reload timer, four pwm outputs, two capture channels
// Assumes: axi4-lite slave, byte registers in the low lane of each word
// Notes:   halt_mode comes from the same clock domain
// Notes on behaviour
// - 8-bit reload counter behind 7-bit prescaler
// - four pwm outputs, frozen in halt
// - output enable drives pin push-pull
// - pwm period is 256 minus reload
// - overflow sets pin to polarity level
// - compare match restores opposite level
// - resolution 1/(256-reload), polarity gives 0/100%
// - timer events raise a wake-up
// - pwm, time base, capture share counter
// - capture csr bits 7:6 read zero
// - edge select: 0 falling, 1 rising
// - per-channel capture interrupt enables
// - flag set by capture, cleared reading value
// - capture value read-only, reset zero, counter
// - capture csr at 0039h
// - capture values at 003Ah, 003Bh
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module art_pwm_timer
	import art_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	input  wire logic              halt_mode,
	input  wire logic [1:0]        capture_in,
	output var  logic [3:0]        pwm_out_pin,
	output var  logic [3:0]        pwm_out_oe,
	output var  logic              irq,
	output var  logic              wakeup
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]        duty_compare_reg_ff [NUM_PWM];
	pwm_ctrl_t         pwm_control_reg_ff;
	tmr_ctrl_t         tmr_ctrl_ff;
	logic [7:0]        count_ff;
	logic [7:0]        reload_value_reg_ff;
	cap_csr_t          csr_ff;
	logic [7:0]        captured_count_ff [NUM_CAP];
	logic [NUM_EVT-1:0] irq_stat_ff;
	logic [NUM_EVT-1:0] irq_mask_ff;
	logic [6:0]        presc_ff;
	logic [3:0]        level_ff;
	logic [1:0]        cap_s1_ff;
	logic [1:0]        cap_s2_ff;
	logic [1:0]        cap_prev_ff;
	logic              aw_held_ff;
	logic              w_held_ff;
	logic [7:0]        aw_idx_ff;
	logic [7:0]        w_byte_ff;
	logic              w_lane_ff;
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic [3:0]        pin_ff;
	logic [3:0]        oe_ff;
	logic              irq_ff;
	logic              wakeup_ff;
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        wr_fire;
	logic        wr_en;
	logic        rd_fire;
	logic [7:0]  ar_idx;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic        wr_hit;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_en   = wr_fire && w_lane_ff;
	assign rd_fire = arvalid && arready_ff;
	assign ar_idx  = araddr[ADDR_W-1:2];
	always_comb
	begin
		wr_hit = (aw_idx_ff >= IDX_DUTY3) && (aw_idx_ff <= IDX_IRQ_MASK);
		rd_hit = 1'b1;
		rd_byte = RST_BYTE;
		unique case (ar_idx)
			IDX_DUTY3:    rd_byte = duty_compare_reg_ff[3];
			IDX_DUTY2:    rd_byte = duty_compare_reg_ff[2];
			IDX_DUTY1:    rd_byte = duty_compare_reg_ff[1];
			IDX_DUTY0:    rd_byte = duty_compare_reg_ff[0];
			IDX_PWM_CTRL: rd_byte = pwm_control_reg_ff;
			IDX_TMR_CTRL: rd_byte = {4'h0, tmr_ctrl_ff.presc_sel, tmr_ctrl_ff.count_enable};
			IDX_COUNT:    rd_byte = count_ff;
			IDX_RELOAD:   rd_byte = reload_value_reg_ff;
			IDX_CAP_CSR:  rd_byte = {2'h0, csr_ff.edge_rising, csr_ff.capture_irq_enable, csr_ff.capture_flag};
			IDX_CAP1:     rd_byte = captured_count_ff[0];
			IDX_CAP2:     rd_byte = captured_count_ff[1];
			IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_ff};
			IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_ff};
			default:      rd_hit = 1'b0;
		endcase
	end
	// ----------------------------------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------------------------------
	// ready is a one-cycle pulse; the master holds valid, so nothing is lost
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b0;
			aw_held_ff <= 1'b0;
			aw_idx_ff  <= RST_BYTE;
		end
		else
		begin
			awready_ff <= awvalid && !awready_ff && !aw_held_ff && !bvalid_ff;
			if (awvalid && awready_ff)
			begin
				aw_held_ff <= 1'b1;
				aw_idx_ff  <= awaddr[ADDR_W-1:2];
			end
			else if (wr_fire)
				aw_held_ff <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_ff <= 1'b0;
			w_held_ff <= 1'b0;
			w_byte_ff <= RST_BYTE;
			w_lane_ff <= 1'b0;
		end
		else
		begin
			wready_ff <= wvalid && !wready_ff && !w_held_ff && !bvalid_ff;
			if (wvalid && wready_ff)
			begin
				w_held_ff <= 1'b1;
				w_byte_ff <= wdata[7:0];
				w_lane_ff <= wstrb[0];
			end
			else if (wr_fire)
				w_held_ff <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid_ff <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
		end
		else
		begin
			arready_ff <= arvalid && !arready_ff && !rvalid_ff;
			if (rd_fire)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= {24'h00_0000, rd_byte};
				rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid_ff <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_control_reg_ff  <= RST_BYTE;
			tmr_ctrl_ff         <= RST_BYTE;
			reload_value_reg_ff <= RST_BYTE;
			irq_mask_ff         <= '0;
		end
		else if (wr_en)
		begin
			if (aw_idx_ff == IDX_PWM_CTRL)
				pwm_control_reg_ff <= w_byte_ff;
			if (aw_idx_ff == IDX_TMR_CTRL)
				tmr_ctrl_ff <= {4'h0, w_byte_ff[3:0]};
			if (aw_idx_ff == IDX_RELOAD)
				reload_value_reg_ff <= w_byte_ff;
			if (aw_idx_ff == IDX_IRQ_MASK)
				irq_mask_ff <= w_byte_ff[NUM_EVT-1:0];
		end
	end
	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	logic       run;
	logic       tick;
	logic       ovf;
	logic [6:0] presc_mask;
	logic [7:0] count_next;
	// halt freezes prescaler and counter, hence the pwm
	assign run        = tmr_ctrl_ff.count_enable && !halt_mode;
	assign presc_mask = PRESC_ONES >> (3'd7 - tmr_ctrl_ff.presc_sel);
	// divide by 2^sel through the 7-bit prescaler
	assign tick       = run && ((presc_ff & presc_mask) == presc_mask);
	assign ovf        = tick && (count_ff == CNT_MAX);
	assign count_next = count_ff + 8'h01;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			presc_ff <= 7'h00;
		else if (run)
			presc_ff <= presc_ff + 7'h01;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_ff <= RST_BYTE;
		else if (wr_en && aw_idx_ff == IDX_COUNT)
			count_ff <= w_byte_ff;
		// reload on overflow sets the period
		else if (ovf)
			count_ff <= reload_value_reg_ff;
		else if (tick)
			count_ff <= count_next;
	end
	// ----------------------------------------------------------------
	// pwm channels
	// ----------------------------------------------------------------
	logic [3:0] nxt_level;
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PWM; gp++)
		begin : g_pwm
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					duty_compare_reg_ff[gp] <= RST_BYTE;
				else if (wr_en && aw_idx_ff == IDX_DUTY0 - 8'(gp))
					duty_compare_reg_ff[gp] <= w_byte_ff;
			end
			// overflow sets, match restores
			// a duty not above reload never matches: steady polarity level
			always_comb
			begin
				nxt_level[gp] = level_ff[gp];
				if (ovf)
					nxt_level[gp] = pwm_control_reg_ff.pwm_output_polarity[gp];
				// restore as the counter reaches duty, so the polarity level spans duty minus reload
				else if (tick && count_next == duty_compare_reg_ff[gp])
					nxt_level[gp] = !pwm_control_reg_ff.pwm_output_polarity[gp];
			end
		end
	endgenerate
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			level_ff <= 4'h0;
			pin_ff   <= 4'h0;
			oe_ff    <= 4'h0;
		end
		else
		begin
			level_ff <= nxt_level;
			pin_ff   <= nxt_level & pwm_control_reg_ff.pwm_output_enable;
			oe_ff    <= pwm_control_reg_ff.pwm_output_enable;
		end
	end
	// ----------------------------------------------------------------
	// capture channels
	// ----------------------------------------------------------------
	logic [1:0] cap_evt;
	logic [1:0] cap_rd;
	logic [1:0] nxt_flag;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cap_s1_ff   <= 2'h0;
			cap_s2_ff   <= 2'h0;
			cap_prev_ff <= 2'h0;
		end
		else
		begin
			cap_s1_ff   <= capture_in;
			cap_s2_ff   <= cap_s1_ff;
			cap_prev_ff <= cap_s2_ff;
		end
	end
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CAP; gc++)
		begin : g_cap
			// edge select picks rising or falling
			assign cap_evt[gc] = csr_ff.edge_rising[gc] ? (cap_s2_ff[gc] && !cap_prev_ff[gc])
			                                            : (!cap_s2_ff[gc] && cap_prev_ff[gc]);
			assign cap_rd[gc]  = rd_fire && ar_idx == IDX_CAP1 + 8'(gc);
			// counter value taken on the event
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					captured_count_ff[gc] <= RST_BYTE;
				else if (cap_evt[gc])
					captured_count_ff[gc] <= count_ff;
			end
			// set wins over the read clear
			assign nxt_flag[gc] = cap_evt[gc] || (csr_ff.capture_flag[gc] && !cap_rd[gc]);
		end
	endgenerate
	// software bits of the capture csr, one process owns the whole byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			csr_ff <= RST_BYTE;
		else
		begin
			csr_ff.capture_flag <= nxt_flag;
			if (wr_en && aw_idx_ff == IDX_CAP_CSR)
			begin
				csr_ff.edge_rising        <= w_byte_ff[5:4];
				csr_ff.capture_irq_enable <= w_byte_ff[3:2];
			end
		end
	end
	// ----------------------------------------------------------------
	// interrupts and wake-up
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] evt;
	logic [NUM_EVT-1:0] stat_clr;
	logic               nxt_irq;
	assign evt      = {cap_evt, ovf};
	assign stat_clr = (wr_en && aw_idx_ff == IDX_IRQ_STAT) ? w_byte_ff[NUM_EVT-1:0] : '0;
	// capture request needs flag and enable
	assign nxt_irq  = |(irq_stat_ff & irq_mask_ff) | |(csr_ff.capture_flag & csr_ff.capture_irq_enable);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_stat_ff <= '0;
		else
			irq_stat_ff <= (irq_stat_ff & ~stat_clr) | evt;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_ff    <= 1'b0;
			wakeup_ff <= 1'b0;
		end
		else
		begin
			irq_ff    <= nxt_irq;
			// pending request wakes from wait or halt
			wakeup_ff <= nxt_irq;
		end
	end
	assign awready     = awready_ff;
	assign wready      = wready_ff;
	assign bvalid      = bvalid_ff;
	assign bresp       = bresp_ff;
	assign arready     = arready_ff;
	assign rvalid      = rvalid_ff;
	assign rdata       = rdata_ff;
	assign rresp       = rresp_ff;
	assign pwm_out_pin = pin_ff;
	assign pwm_out_oe  = oe_ff;
	assign irq         = irq_ff;
	assign wakeup      = wakeup_ff;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_halt_freezes_count: assert property (halt_mode && !(wr_en && aw_idx_ff == IDX_COUNT) |=> $stable(count_ff))
		else $error("counter moved in halt");
	a_reload_on_ovf: assert property (ovf && !(wr_en && aw_idx_ff == IDX_COUNT) |=> count_ff == $past(reload_value_reg_ff))
		else $error("no reload on overflow");
	a_ovf_sets_level: assert property (ovf |=> level_ff == $past(pwm_control_reg_ff.pwm_output_polarity))
		else $error("overflow level wrong");
	a_match_restores: assert property (tick && !ovf && count_next == duty_compare_reg_ff[0] |=> level_ff[0] == !$past(pwm_control_reg_ff.pwm_output_polarity[0]))
		else $error("compare did not restore");
	a_pin_gated_oe: assert property (!pwm_control_reg_ff.pwm_output_enable[1] |=> pwm_out_pin[1] == 1'b0 && !pwm_out_oe[1])
		else $error("disabled pin driven");
	a_reserved_zero: assert property (rd_fire && ar_idx == IDX_CAP_CSR |=> rdata[7:6] == 2'h0)
		else $error("reserved bits not zero");
	a_capture_loads: assert property (cap_evt[0] |=> captured_count_ff[0] == $past(count_ff) && csr_ff.capture_flag[0])
		else $error("capture not loaded");
	a_read_clears_flag: assert property (cap_rd[1] && !cap_evt[1] |=> !csr_ff.capture_flag[1])
		else $error("flag not cleared by read");
	a_cap_irq_raise: assert property (csr_ff.capture_flag[0] && csr_ff.capture_irq_enable[0] |=> irq && wakeup)
		else $error("capture irq missing");
	c_overflow: cover property (ovf ##[1:600] ovf);
	c_capture_read: cover property (cap_evt[1] ##[1:50] cap_rd[1]);
	c_write_resp: cover property (wr_fire ##1 bvalid && bready);
endmodule
`default_nettype wire

// >>> testbench/sig_source.sv
// Purpose: far-side model of the two capture signal sources
// Assumes: pins are asynchronous to aclk
// Notes:   slow mode holds each commanded level change back
`timescale 1ns/1ns
`default_nettype none
module sig_source
(
	input  wire logic       aclk,
	input  wire logic [1:0] want,
	input  wire logic       slow,
	output var  logic [1:0] capture_in
);
	int wait_cnt;
	initial
	begin
		capture_in = 2'h0;
		wait_cnt = 0;
	end
	// ----------------------------------------------------------------
	// level changes
	// ----------------------------------------------------------------
	// off-edge change, pins have no relation to the clock
	always @(posedge aclk)
	begin
		if (want !== capture_in)
		begin
			wait_cnt = slow ? 4 : 0;
			repeat (wait_cnt) @(posedge aclk);
			capture_in <= #3 want;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the pwm / capture timer
// Assumes: one clock, registers over axi4-lite
// Notes:   register model in associative arrays
`timescale 1ns/1ns
`default_nettype none
module testbench
	import art_pkg::*;
();
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_mode, slow;
	logic              awready, wready, bvalid, arready, rvalid, irq, wakeup, a0, a1, p;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d1, d2;
	logic [3:0]        wstrb, pwm_out_pin, pwm_out_oe, pol, snap;
	logic [1:0]        bresp, rresp, capture_in, want, r;
	logic [15:0]       rnd;
	logic [7:0]        v;
	int                n_fail, checks_done, rl, per, hi, ex, c, k;
	int                mdl[int];
	int                wm[int];
	int                duty[4];
	int                wmt[13] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h3C, 0, 0, 0, 8'h07};

	art_pwm_timer art_pwm_timer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .halt_mode(halt_mode),
		.capture_in(capture_in), .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe), .irq(irq),
		.wakeup(wakeup));
	sig_source sig_source_inst (.aclk(aclk), .want(want), .slow(slow), .capture_in(capture_in));

	initial aclk = 1'b0;
	always #4 aclk = ~aclk;
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_count(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			n_fail++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// ----------------------------------------------------------------
	// bus master and register model
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		logic [1:0] rs;
		axi_wr(idx, d, rs);
		chk_data({30'h0, rs}, mdl.exists(idx) ? RESP_OKAY : RESP_SLVERR);
		if (idx == IDX_IRQ_STAT)
			mdl[idx] = mdl[idx] & ~int'(d);
		else if (mdl.exists(idx))
			mdl[idx] = (mdl[idx] & ~wm[idx]) | (d & wm[idx]);
	endtask
	task automatic reg_chk(input logic [7:0] idx);
		logic [31:0] d;
		logic [1:0]  rs;
		axi_rd(idx, d, rs);
		chk_data(d, mdl.exists(idx) ? mdl[idx] : 0);
		chk_data({30'h0, rs}, mdl.exists(idx) ? RESP_OKAY : RESP_SLVERR);
		if (idx == IDX_CAP1)
			mdl[IDX_CAP_CSR] &= ~1;
		if (idx == IDX_CAP2)
			mdl[IDX_CAP_CSR] &= ~2;
	endtask
	// gap between the 2nd and 3rd rise, the first may be cut by a reconfigure
	task automatic rise_gap(output int g);
		k = 0;
		g = 0;
		p = pwm_out_pin[0];
		while (k < 3)
		begin
			@(posedge aclk);
			g++;
			if (pwm_out_pin[0] === 1'b1 && p === 1'b0)
			begin
				k++;
				if (k < 3)
					g = 0;
			end
			p = pwm_out_pin[0];
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, halt_mode, slow} = 7'h00;
		awaddr = '0;
		araddr = '0;
		wdata = 32'h0;
		wstrb = 4'hF;
		want = 2'h0;
		aresetn = 1'b0;
		n_fail = 0;
		checks_done = 0;
		rnd = 16'h520B;
		for (int i = 0; i < 13; i++)
		begin
			mdl[8'h31 + i] = 0;
			wm[8'h31 + i] = wmt[i];
		end
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 8'h31; i <= 8'h3D; i++)
			reg_chk(8'(i));
		reg_chk(8'h10);
		reg_wr(8'h10, 8'h11);
		reg_wr(IDX_CAP_CSR, 8'hFF);
		reg_chk(IDX_CAP_CSR);
		reg_wr(IDX_CAP1, 8'h5A);
		reg_chk(IDX_CAP1);
		rnd = lfsr(rnd);
		rl = 8'hC0 + (rnd % 56);
		per = 256 - rl;
		rnd = lfsr(rnd);
		pol = rnd[3:0];
		for (int n = 0; n < 4; n++)
		begin
			rnd = lfsr(rnd);
			// duty above reload, last one held off
			duty[n] = (n == 3) ? 0 : rl + 1 + (rnd % (255 - rl));
			reg_wr(8'(IDX_DUTY0 - n), 8'(duty[n]));
		end
		reg_wr(IDX_RELOAD, 8'(rl));
		reg_wr(IDX_PWM_CTRL, {4'hF, pol});
		reg_wr(IDX_TMR_CTRL, 8'h01);
		// first period climbs from zero, wait past the first overflow
		repeat (256 + per) @(posedge aclk);
		chk_data(pwm_out_oe, 4'hF);
		for (int n = 0; n < 4; n++)
		begin
			hi = 0;
			repeat (per)
			begin
				@(posedge aclk);
				hi += (pwm_out_pin[n] === 1'b1);
			end
			ex = (duty[n] == 0) ? per : duty[n] - rl;
			chk_count(hi, pol[n] ? ex : per - ex);
		end
		for (int s = 0; s <= 2; s += 2)
		begin
			reg_wr(IDX_TMR_CTRL, 8'(2 * s + 1));
			rise_gap(c);
			chk_count(c, per << s);
		end
		mdl[IDX_IRQ_STAT] |= 1;
		reg_wr(IDX_TMR_CTRL, 8'h01);
		halt_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		snap = pwm_out_pin;
		axi_rd(IDX_COUNT, d1, r);
		repeat (2 * per)
		begin
			@(posedge aclk);
			chk_data(pwm_out_pin, snap);
		end
		axi_rd(IDX_COUNT, d2, r);
		chk_data(d2, d1);
		halt_mode <= 1'b0;
		reg_wr(IDX_PWM_CTRL, {4'h0, pol});
		repeat (3) @(posedge aclk);
		chk_data({pwm_out_oe, pwm_out_pin}, 8'h00);
		rnd = lfsr(rnd);
		v = rnd[7:0];
		reg_wr(IDX_TMR_CTRL, 8'h00);
		reg_wr(IDX_COUNT, v);
		reg_wr(IDX_CAP_CSR, 8'h14);
		want <= 2'h3;
		repeat (12) @(posedge aclk);
		mdl[IDX_CAP_CSR] |= 1;
		mdl[IDX_CAP1] = v;
		mdl[IDX_IRQ_STAT] |= 2;
		chk_data({irq, wakeup}, 2'h3);
		reg_chk(IDX_CAP_CSR);
		reg_wr(IDX_COUNT, ~v);
		slow <= 1'b1;
		want <= 2'h0;
		repeat (16) @(posedge aclk);
		mdl[IDX_CAP_CSR] |= 2;
		mdl[IDX_CAP2] = 8'(~v);
		mdl[IDX_IRQ_STAT] |= 4;
		reg_chk(IDX_CAP_CSR);
		reg_chk(IDX_CAP1);
		reg_chk(IDX_CAP2);
		reg_chk(IDX_CAP_CSR);
		reg_chk(IDX_IRQ_STAT);
		reg_wr(IDX_IRQ_MASK, 8'h00);
		repeat (3) @(posedge aclk);
		a0 = irq;
		reg_wr(IDX_IRQ_MASK, 8'h07);
		reg_chk(IDX_IRQ_MASK);
		repeat (3) @(posedge aclk);
		a1 = irq;
		chk_data({30'h0, a0, a1}, 32'h1);
		reg_wr(IDX_IRQ_STAT, 8'h07);
		reg_chk(IDX_IRQ_STAT);
		repeat (3) @(posedge aclk);
		chk_data({irq, wakeup}, 2'h0);
		stop_test();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire
